// [hw/avcdg_top.sv]
// Chosen here: the AXI4-Lite register port.
module avcdg_top (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    system_source_clock,
   input  wire logic                    audio_source_clock,
   output avcdg_pkg::avcdg_clk_en_s     clk_en,
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [11:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);
   avcdg_pkg::avcdg_div_s    vdiv_q, vdiv_d, sdiv_q, sdiv_d;
   logic [2:0]               vgate_q, vgate_d;
   logic [3:0]               agate_q, agate_d;
   logic                     bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]              rdata_q, rdata_d;
   avcdg_pkg::avcdg_clk_en_s en_q, en_d;
   logic                     wr_go, rd_go, voice_tick, sound_tick;

   function automatic logic mapped(input logic [11:0] a);
      return a == avcdg_pkg::VOICE_DIV_OFFSET || a == avcdg_pkg::SOUND_DIV_OFFSET ||
             a == avcdg_pkg::VOICE_GATE_OFFSET || a == avcdg_pkg::AUDIO_GATE_OFFSET;
   endfunction

   function automatic avcdg_pkg::avcdg_div_s div_write(input avcdg_pkg::avcdg_div_s cur,
                                                       input logic [7:0] b);
      avcdg_pkg::avcdg_div_s n;
      n     = cur;
      n.run = b[avcdg_pkg::DIV_RUN_BIT];
      if (cur.run) begin
         n.ratio = b[avcdg_pkg::DIV_RATIO_MSB:0];
      end
      return n;
   endfunction

   // Write waits for both channels so the response follows both
   assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   assign rd_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign clk_en        = en_q;

   always_comb begin
      vdiv_d   = vdiv_q;
      sdiv_d   = sdiv_q;
      vgate_d  = vgate_q;
      agate_d  = agate_q;
      bvalid_d = bvalid_q && !s_axi_bready;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q && !s_axi_rready;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d  = mapped(s_axi_awaddr) ? avcdg_pkg::RESP_OKAY : avcdg_pkg::RESP_SLVERR;
         // All fields sit in byte lane 0
         if (s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
               avcdg_pkg::VOICE_DIV_OFFSET:  vdiv_d  = div_write(vdiv_q, s_axi_wdata[7:0]);
               avcdg_pkg::SOUND_DIV_OFFSET:  sdiv_d  = div_write(sdiv_q, s_axi_wdata[7:0]);
               avcdg_pkg::VOICE_GATE_OFFSET: vgate_d = s_axi_wdata[2:0];
               avcdg_pkg::AUDIO_GATE_OFFSET: agate_d = s_axi_wdata[3:0];
               default: ;
            endcase
         end
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(s_axi_araddr) ? avcdg_pkg::RESP_OKAY : avcdg_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            avcdg_pkg::VOICE_DIV_OFFSET:  rdata_d = {27'h0, vdiv_q};
            avcdg_pkg::SOUND_DIV_OFFSET:  rdata_d = {27'h0, sdiv_q};
            avcdg_pkg::VOICE_GATE_OFFSET: rdata_d = {29'h0, vgate_q};
            avcdg_pkg::AUDIO_GATE_OFFSET: rdata_d = {28'h0, agate_q};
            default:                      rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         vdiv_q   <= '{run: avcdg_pkg::DIV_RUN_RESET, ratio: avcdg_pkg::VOICE_RATIO_RESET};
         sdiv_q   <= '{run: avcdg_pkg::DIV_RUN_RESET, ratio: avcdg_pkg::SOUND_RATIO_RESET};
         vgate_q  <= avcdg_pkg::VOICE_GATE_RESET;
         agate_q  <= avcdg_pkg::AUDIO_GATE_RESET;
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
         rvalid_q <= 1'b0;
         rresp_q  <= 2'h0;
         rdata_q  <= 32'h0;
      end else begin
         vdiv_q   <= vdiv_d;
         sdiv_q   <= sdiv_d;
         vgate_q  <= vgate_d;
         agate_q  <= agate_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   avcdg_divider #(
      .RESET_RATIO (avcdg_pkg::VOICE_RATIO_RESET)
   ) u_voice_div (
      .clk      (clk),
      .reset    (reset),
      .src_tick (system_source_clock),
      .run      (vdiv_q.run),
      .ratio    (vdiv_q.ratio),
      .div_tick (voice_tick)
   );

   avcdg_divider #(
      .RESET_RATIO (avcdg_pkg::SOUND_RATIO_RESET)
   ) u_sound_div (
      .clk      (clk),
      .reset    (reset),
      .src_tick (audio_source_clock),
      .run      (sdiv_q.run),
      .ratio    (sdiv_q.ratio),
      .div_tick (sound_tick)
   );

   // voice and sound_detect gates act on whole registered ticks; pdm and i2s gates act on raw audio_source_clock
   always_comb begin
      en_d.voice_bus           = voice_tick && vgate_q[avcdg_pkg::VG_VOICE_BUS_BIT];
      en_d.processor_interface = voice_tick && vgate_q[avcdg_pkg::VG_PROC_IF_BIT];
      en_d.programmable_fabric = voice_tick && vgate_q[avcdg_pkg::VG_FABRIC_BIT];
      en_d.pdm_left            = audio_source_clock && agate_q[avcdg_pkg::AG_PDM_LEFT_BIT];
      en_d.pdm_right           = audio_source_clock && agate_q[avcdg_pkg::AG_PDM_RIGHT_BIT];
      en_d.i2s_master          = audio_source_clock && agate_q[avcdg_pkg::AG_I2S_MASTER_BIT];
      en_d.sound_detect        = sound_tick && agate_q[avcdg_pkg::AG_SOUND_DET_BIT];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         en_q <= '0;
      end else begin
         en_q <= en_d;
      end
   end

   sequence voice_div_write_s;
      wr_go && s_axi_wstrb[0] && s_axi_awaddr == avcdg_pkg::VOICE_DIV_OFFSET;
   endsequence

   sequence sound_div_write_s;
      wr_go && s_axi_wstrb[0] && s_axi_awaddr == avcdg_pkg::SOUND_DIV_OFFSET;
   endsequence

   AST_VOICE_RATIO_LOCK: assert property (@(posedge clk) disable iff (reset)
      voice_div_write_s and !vdiv_q.run |=> vdiv_q.ratio == $past(vdiv_q.ratio))
      else $error("voice ratio changed while stopped");

   AST_SOUND_RATIO_TAKE: assert property (@(posedge clk) disable iff (reset)
      sound_div_write_s and sdiv_q.run |=> sdiv_q.ratio == $past(s_axi_wdata[3:0]))
      else $error("sound ratio write lost while running");

   // First edge after release sees reset values
   AST_RUN_RESET: assert property (@(posedge clk)
      $past(reset) && !reset |-> vdiv_q.run == avcdg_pkg::DIV_RUN_RESET &&
         sdiv_q.run == avcdg_pkg::DIV_RUN_RESET && vdiv_q.ratio == avcdg_pkg::VOICE_RATIO_RESET &&
         sdiv_q.ratio == avcdg_pkg::SOUND_RATIO_RESET)
      else $error("divider reset values wrong");

   AST_GATES_RESET: assert property (@(posedge clk)
      $past(reset) && !reset |-> vgate_q == avcdg_pkg::VOICE_GATE_RESET &&
         agate_q == avcdg_pkg::AUDIO_GATE_RESET && en_q == '0)
      else $error("gate reset values wrong");

   AST_VOICE_GATE: assert property (@(posedge clk) disable iff (reset)
      en_q.programmable_fabric |-> $past(voice_tick) && $past(vgate_q[2]))
      else $error("fabric clock ran while gated");

   AST_AUDIO_GATE: assert property (@(posedge clk) disable iff (reset)
      audio_source_clock && agate_q[1] |=> en_q.pdm_right)
      else $error("pdm right clock missing");

   AST_SOUND_GATE: assert property (@(posedge clk) disable iff (reset)
      !agate_q[3] ##1 !agate_q[3] |-> !en_q.sound_detect)
      else $error("sound clock ran while gated");

   AST_WRITE_RESP: assert property (@(posedge clk) disable iff (reset)
      wr_go |=> bvalid_q ##0 (bresp_q == avcdg_pkg::RESP_OKAY) == $past(mapped(s_axi_awaddr)))
      else $error("write response wrong");
endmodule

// [hw/avcdg_pkg.sv]
package avcdg_pkg;

   // Register byte offsets
   localparam logic [11:0] VOICE_DIV_OFFSET  = 12'h114;
   localparam logic [11:0] SOUND_DIV_OFFSET  = 12'h118;
   localparam logic [11:0] VOICE_GATE_OFFSET = 12'h11C;
   localparam logic [11:0] AUDIO_GATE_OFFSET = 12'h120;

   // Divider control fields
   localparam int          DIV_RUN_BIT       = 4;
   localparam int          DIV_RATIO_MSB     = 3;
   localparam int          RATIO_WIDTH       = 4;
   localparam logic        DIV_RUN_RESET     = 1'h1;
   localparam logic [3:0]  VOICE_RATIO_RESET = 4'h1;
   localparam logic [3:0]  SOUND_RATIO_RESET = 4'h3;

   // Gate fields
   localparam int          VG_VOICE_BUS_BIT  = 0;
   localparam int          VG_PROC_IF_BIT    = 1;
   localparam int          VG_FABRIC_BIT     = 2;
   localparam int          AG_PDM_LEFT_BIT   = 0;
   localparam int          AG_PDM_RIGHT_BIT  = 1;
   localparam int          AG_I2S_MASTER_BIT = 2;
   localparam int          AG_SOUND_DET_BIT  = 3;
   localparam logic [2:0]  VOICE_GATE_RESET  = 3'h0;
   localparam logic [3:0]  AUDIO_GATE_RESET  = 4'h0;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   typedef struct packed {
      logic       run;
      logic [3:0] ratio;
   } avcdg_div_s;

   typedef struct packed {
      logic voice_bus;
      logic processor_interface;
      logic programmable_fabric;
      logic pdm_left;
      logic pdm_right;
      logic i2s_master;
      logic sound_detect;
   } avcdg_clk_en_s;

endpackage

// [hw/avcdg_divider.sv]
module avcdg_divider #(
   parameter logic [3:0] RESET_RATIO = 4'h1
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       src_tick,
   input  wire logic       run,
   input  wire logic [3:0] ratio,
   output logic            div_tick
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] act_q;
   logic [3:0] act_d;
   logic       tick_q;
   logic       tick_d;

   always_comb begin
      cnt_d  = cnt_q;
      act_d  = act_q;
      tick_d = 1'b0;
      if (!run) begin
         cnt_d = 4'h0;
         act_d = ratio;
      end else if (src_tick) begin
         if (cnt_q == act_q) begin
            cnt_d  = 4'h0;
            tick_d = 1'b1;
            act_d  = ratio;
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q  <= 4'h0;
         act_q  <= RESET_RATIO;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         act_q  <= act_d;
         tick_q <= tick_d;
      end
   end

   assign div_tick = tick_q;

   // tick only from a source edge
   AST_DIV_FROM_SRC: assert property (@(posedge clk) disable iff (reset)
      tick_q |-> $past(src_tick) && $past(run))
      else $error("divided tick without source tick");

   AST_DIV_STOPPED: assert property (@(posedge clk) disable iff (reset)
      !run ##1 !run |-> !tick_q)
      else $error("divided tick while stopped");

   AST_DIV_BYPASS: assert property (@(posedge clk) disable iff (reset)
      run && src_tick && act_q == 4'h0 |=> tick_q)
      else $error("ratio zero did not pass source");
endmodule

// [tb/avcdg_top_tb.sv]
module avcdg_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     clk     = 1'b0;
   logic                     reset   = 1'b1;
   logic                     sys_src = 1'b0;
   logic                     aud_src = 1'b0;
   avcdg_pkg::avcdg_clk_en_s clk_en;
   logic [11:0]              awaddr  = 12'h0;
   logic [11:0]              araddr  = 12'h0;
   logic [31:0]              wdata   = 32'h0;
   logic [3:0]               wstrb   = 4'h0;
   logic                     awvalid = 1'b0;
   logic                     wvalid  = 1'b0;
   logic                     bready  = 1'b0;
   logic                     arvalid = 1'b0;
   logic                     rready  = 1'b0;
   logic                     awready, wready, bvalid, arready, rvalid;
   logic [1:0]               bresp, rresp;
   logic [31:0]              rdata;
   logic [31:0]              mreg [4];
   int                       cnt [7];
   int                       error_cnt = 0;
   int                       compares  = 0;

   always #12.5 clk = ~clk;

   // Count output enable pulses, lsb first
   always @(posedge clk) begin
      for (int i = 0; i < 7; i++) begin
         if (clk_en[i] === 1'b1) begin
            cnt[i]++;
         end
      end
   end

   avcdg_top avcdg_top_i (
      .clk(clk), .reset(reset), .system_source_clock(sys_src), .audio_source_clock(aud_src), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   task automatic give_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tmo();
      error_cnt++;
      $display("[ERR] handshake expected answer seen timeout");
      give_verdict();
   endtask

   // Model index of a register, -1 when unmapped
   function automatic int idx(input logic [11:0] a);
      if (a[1:0] == 2'h0 && a >= 12'h114 && a <= 12'h120) begin
         return int'((a - 12'h114) >> 2);
      end
      return -1;
   endfunction

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      int k;
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      k = idx(a);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20 && !(aw_ok && w_ok); n++) begin
         @(posedge clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      if (!(aw_ok && w_ok)) tmo();
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (bvalid === 1'b1) break;
      end
      if (n == 20) tmo();
      chk("bresp", (k < 0) ? 32'h2 : 32'h0, {30'h0, bresp});
      // Ratio kept while stopped, gate fields masked
      if (k >= 0 && s[0]) begin
         if (k < 2) begin
            if (mreg[k][4]) mreg[k][3:0] = d[3:0];
            mreg[k][4] = d[4];
         end else begin
            mreg[k] = d & ((k == 2) ? 32'h7 : 32'hF);
         end
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a);
      int n;
      int k;
      k = idx(a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (arready === 1'b1) break;
      end
      if (n == 20) tmo();
      arvalid <= 1'b0;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (rvalid === 1'b1) break;
      end
      if (n == 20) tmo();
      chk("rdata", (k < 0) ? 32'h0 : mreg[k], rdata);
      chk("rresp", (k < 0) ? 32'h2 : 32'h0, {30'h0, rresp});
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // Random source pulses, counts compared with the model
   task automatic burst(input int ncyc);
      int ps;
      int pa;
      int v;
      int sd;
      int e [7];
      bit b1;
      bit b2;
      ps = 0;
      pa = 0;
      // Restart clears divider phase; gate and ratio kept apart
      for (int k = 0; k < 2; k++) begin
         if (mreg[k][4]) begin
            wr(12'h114 + 12'(4 * k), mreg[k] & 32'hF, 4'hF);
            wr(12'h114 + 12'(4 * k), mreg[k] | 32'h10, 4'hF);
         end
      end
      foreach (cnt[i]) cnt[i] = 0;
      for (int c = 0; c < ncyc; c++) begin
         b1 = 1'($urandom);
         b2 = 1'($urandom);
         sys_src <= b1;
         aud_src <= b2;
         ps += int'(b1);
         pa += int'(b2);
         @(posedge clk);
      end
      sys_src <= 1'b0;
      aud_src <= 1'b0;
      repeat (6) @(posedge clk);
      v = mreg[0][4] ? ps / (int'(mreg[0][3:0]) + 1) : 0;
      sd = mreg[1][4] ? pa / (int'(mreg[1][3:0]) + 1) : 0;
      e = '{mreg[3][3] ? sd : 0, mreg[3][2] ? pa : 0, mreg[3][1] ? pa : 0, mreg[3][0] ? pa : 0,
            mreg[2][2] ? v : 0, mreg[2][1] ? v : 0, mreg[2][0] ? v : 0};
      for (int i = 0; i < 7; i++) begin
         chk("clk_en pulse count", 32'(e[i]), 32'(cnt[i]));
      end
   endtask

   initial begin
      void'($urandom(32'hFE05E0FB));
      mreg = '{32'h11, 32'h13, 32'h0, 32'h0};
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 4; k++) rd(12'h114 + 12'(4 * k));
      rd(12'h124);
      wr(12'h128, 32'hFF, 4'hF);
      burst(40);
      for (int r = 0; r < 16; r++) begin
         wr(12'h114, {27'h0, 1'b1, r[3:0]}, 4'hF);
         wr(12'h118, {27'h0, 1'b1, 4'(15 - r)}, 4'hF);
         wr(12'h11C, $urandom, 4'hF);
         wr(12'h120, $urandom | 32'h8, 4'hF);
         rd(12'h114);
         rd(12'h118);
         burst(120);
      end
      wr(12'h11C, 32'h7, 4'hF);
      for (int k = 0; k < 2; k++) begin
         wr(12'h114 + 12'(4 * k), 32'h12, 4'hF);
         wr(12'h114 + 12'(4 * k), 32'h02, 4'hF);
         wr(12'h114 + 12'(4 * k), 32'h09, 4'hF);
         wr(12'h114 + 12'(4 * k), 32'h1E, 4'h0);
         rd(12'h114 + 12'(4 * k));
      end
      burst(60);
      wr(12'h114, 32'h12, 4'hF);
      wr(12'h118, 32'h12, 4'hF);
      burst(90);
      // Mid-run reset restores every field
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      mreg = '{32'h11, 32'h13, 32'h0, 32'h0};
      repeat (2) @(posedge clk);
      chk("clk_en after reset", 32'h0, {25'h0, clk_en});
      for (int k = 0; k < 4; k++) rd(12'h114 + 12'(4 * k));
      give_verdict();
   end
endmodule
